/* boxu_decode.v */
`timescale 1ns/1ps
`include "boxu_defines.vh"

module boxu_decode (
    input  wire [13:0] instr,
    output wire        is_bitop,
    output wire [1:0]  op,
    output wire [2:0]  bit_pos,
    output wire [6:0]  file_addr
);
    assign is_bitop  = (instr[`BOXU_CLASS_HI:`BOXU_CLASS_LO] == `BOXU_CLASS_BITOP)
                       && (instr[`BOXU_OP_HI:`BOXU_OP_LO] != 2'h3);
    assign op        = instr[`BOXU_OP_HI:`BOXU_OP_LO];
    assign bit_pos   = instr[`BOXU_BIT_HI:`BOXU_BIT_LO];
    assign file_addr = instr[`BOXU_ADDR_HI:`BOXU_ADDR_LO];
endmodule // boxu_decode

/* boxu_defines.vh */
`ifndef BOXU_DEFINES_VH
`define BOXU_DEFINES_VH

// instruction word layout
`define BOXU_IW_W          14
`define BOXU_CLASS_HI      13
`define BOXU_CLASS_LO      12
`define BOXU_CLASS_BITOP   2'h1
`define BOXU_OP_HI         11
`define BOXU_OP_LO         10
`define BOXU_OP_CLR        2'h0
`define BOXU_OP_SET        2'h1
`define BOXU_OP_TSC        2'h2
`define BOXU_BIT_HI        9
`define BOXU_BIT_LO        7
`define BOXU_ADDR_HI       6
`define BOXU_ADDR_LO       0
`define BOXU_ADDR_W        7
`define BOXU_BIT_W         3
`define BOXU_DATA_W        8

// phase sequencer: four phases per instruction cycle
`define BOXU_PH_Q1         2'h0
`define BOXU_PH_Q2         2'h1
`define BOXU_PH_Q3         2'h2
`define BOXU_PH_Q4         2'h3

// reset values
`define BOXU_RST_IR        14'h0000
`define BOXU_RST_ADDR      7'h00
`define BOXU_RST_DATA      8'h00

`endif

/* boxu_exec.v */
`timescale 1ns/1ps
`include "boxu_defines.vh"

// Functional notes
// - clear_file_bit writes 0 to the chosen bit of the file register, keeps the rest, no flags.
// - set_file_bit writes 1 to the chosen bit of the file register, keeps the rest, no flags.
// - operands are a 7-bit file address 0..127 and a 3-bit bit position 0..7.
// - test_bit_skip_when_clear runs the next word if the bit is 1, else flushes it to a NOP.
module boxu_exec (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [13:0] instr,
    input  wire        instr_valid,
    output wire [6:0]  rd_addr,
    output wire        rd_en,
    input  wire [7:0]  rd_data,
    output wire [6:0]  wr_addr,
    output wire [7:0]  wr_data,
    output wire        wr_en,
    output wire        status_wr_en,
    output wire        skip_next,
    output wire        nop_cycle,
    output wire [1:0]  phase,
    output wire        cycle_end,
    output wire        busy
);
    reg         rst_s1_r;
    reg         rst_s2_r;
    wire        rst_n;
    reg  [1:0]  phase_r;
    reg  [1:0]  phase_nxt;
    reg  [13:0] ir_r;
    reg  [13:0] ir_nxt;
    reg         ir_ok_r;
    reg         ir_ok_nxt;
    reg         flush_r;
    reg         flush_nxt;
    reg  [7:0]  opnd_r;
    reg  [7:0]  opnd_nxt;
    reg  [6:0]  rd_addr_r;
    reg  [6:0]  rd_addr_nxt;
    reg         rd_en_r;
    reg         rd_en_nxt;
    reg  [6:0]  wr_addr_r;
    reg  [6:0]  wr_addr_nxt;
    reg  [7:0]  wr_data_r;
    reg  [7:0]  wr_data_nxt;
    reg         wr_en_r;
    reg         wr_en_nxt;
    reg         skip_next_r;
    reg         skip_next_nxt;
    reg         nop_cycle_r;
    reg         nop_cycle_nxt;
    reg         cycle_end_r;
    reg         cycle_end_nxt;
    reg         busy_r;
    reg         busy_nxt;
    wire        is_bitop;
    wire [1:0]  op;
    wire [2:0]  bit_pos;
    wire [6:0]  file_addr;
    wire        bit_zero;

    // bit mask helper, used by both write paths
    function [7:0] bit_mask;
        input [2:0] b;
        begin
            bit_mask = 8'h01 << b;
        end
    endfunction

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    boxu_decode u_dec (
        .instr     (ir_r),
        .is_bitop  (is_bitop),
        .op        (op),
        .bit_pos   (bit_pos),
        .file_addr (file_addr)
    );

    // bit ops never touch status flags
    assign status_wr_en = 1'h0;
    assign phase        = phase_r;
    assign rd_addr      = rd_addr_r;
    assign rd_en        = rd_en_r;
    assign wr_addr      = wr_addr_r;
    assign wr_data      = wr_data_r;
    assign wr_en        = wr_en_r;
    assign skip_next    = skip_next_r;
    assign nop_cycle    = nop_cycle_r;
    assign cycle_end    = cycle_end_r;
    assign busy         = busy_r;

    // only the tested bit decides the skip, the other seven are ignored
    assign bit_zero = ((opnd_r & bit_mask(bit_pos)) == 8'h00);

    // one bit forced to a level, the other seven passed through
    function [7:0] bit_put;
        input [7:0] val;
        input [2:0] b;
        input       lvl;
        begin
            if (lvl) begin
                bit_put = val | bit_mask(b);
            end else begin
                bit_put = val & ~bit_mask(b);
            end
        end
    endfunction

    // next state: one instruction cycle is four phases, Q1..Q4
    always @* begin
        phase_nxt     = phase_r + 2'h1;
        ir_nxt        = ir_r;
        ir_ok_nxt     = ir_ok_r;
        flush_nxt     = flush_r;
        opnd_nxt      = opnd_r;
        rd_addr_nxt   = rd_addr_r;
        rd_en_nxt     = 1'h0;
        wr_addr_nxt   = wr_addr_r;
        wr_data_nxt   = wr_data_r;
        wr_en_nxt     = 1'h0;
        skip_next_nxt = 1'h0;
        nop_cycle_nxt = nop_cycle_r;
        cycle_end_nxt = 1'h0;
        busy_nxt      = busy_r;
        case (phase_r)
            `BOXU_PH_Q1: begin
                // latch decode; a flushed slot becomes a NOP cycle
                ir_nxt        = instr;
                ir_ok_nxt     = instr_valid && !flush_r;
                nop_cycle_nxt = flush_r;
                flush_nxt     = 1'h0;
                busy_nxt      = instr_valid || flush_r;
            end
            `BOXU_PH_Q2: begin
                if (ir_ok_r && is_bitop) begin
                    rd_addr_nxt = file_addr;
                    rd_en_nxt   = 1'h1;
                end
            end
            `BOXU_PH_Q3: begin
                // file data is only promised while rd_en stands
                opnd_nxt = rd_data;
            end
            `BOXU_PH_Q4: begin
                cycle_end_nxt = 1'h1;
                busy_nxt      = 1'h0;
                // write lands on the next Q1 edge, ahead of the next word's Q3 read
                if (ir_ok_r && is_bitop) begin
                    case (op)
                        `BOXU_OP_CLR: begin
                            wr_addr_nxt = file_addr;
                            wr_data_nxt = bit_put(opnd_r, bit_pos, 1'h0);
                            wr_en_nxt   = 1'h1;
                        end
                        `BOXU_OP_SET: begin
                            wr_addr_nxt = file_addr;
                            wr_data_nxt = bit_put(opnd_r, bit_pos, 1'h1);
                            wr_en_nxt   = 1'h1;
                        end
                        `BOXU_OP_TSC: begin
                            // zero bit: kill the following fetched word
                            if (bit_zero) begin
                                flush_nxt     = 1'h1;
                                skip_next_nxt = 1'h1;
                            end
                        end
                        default: begin
                            wr_en_nxt = 1'h0;
                        end
                    endcase
                end
            end
            default: begin
                phase_nxt = `BOXU_PH_Q1;
            end
        endcase
    end

    // registers only; all decisions are in the next-state block
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_r     <= `BOXU_PH_Q1;
            ir_r        <= `BOXU_RST_IR;
            ir_ok_r     <= 1'h0;
            flush_r     <= 1'h0;
            opnd_r      <= `BOXU_RST_DATA;
            rd_addr_r   <= `BOXU_RST_ADDR;
            rd_en_r     <= 1'h0;
            wr_addr_r   <= `BOXU_RST_ADDR;
            wr_data_r   <= `BOXU_RST_DATA;
            wr_en_r     <= 1'h0;
            skip_next_r <= 1'h0;
            nop_cycle_r <= 1'h0;
            cycle_end_r <= 1'h0;
            busy_r      <= 1'h0;
        end else begin
            phase_r     <= phase_nxt;
            ir_r        <= ir_nxt;
            ir_ok_r     <= ir_ok_nxt;
            flush_r     <= flush_nxt;
            opnd_r      <= opnd_nxt;
            rd_addr_r   <= rd_addr_nxt;
            rd_en_r     <= rd_en_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wr_data_r   <= wr_data_nxt;
            wr_en_r     <= wr_en_nxt;
            skip_next_r <= skip_next_nxt;
            nop_cycle_r <= nop_cycle_nxt;
            cycle_end_r <= cycle_end_nxt;
            busy_r      <= busy_nxt;
        end
    end
endmodule // boxu_exec

/* boxu_exec_props.sv */
`timescale 1ns/1ps
module boxu_exec_props (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        instr_valid,
    input wire logic        wr_en,
    input wire logic        skip_next,
    input wire logic        nop_cycle,
    input wire logic [13:0] instr,
    input wire logic [7:0]  rd_data,
    input wire logic [7:0]  wr_data,
    input wire logic [6:0]  wr_addr,
    input wire logic [1:0]  phase,
    input wire logic        cycle_end,
    input wire logic        busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a word taken while skip_next shows is the flushed one
    wire       tk = phase == 2'h0 && instr_valid && instr[13:12] == 2'h1 && !skip_next;
    wire [7:0] m  = 8'h01 << instr[9:7];
    a_clr_write: assert property (tk && instr[11:10] == 2'h0 |-> ##4 wr_en &&
        wr_addr == $past(instr[6:0], 4) && wr_data == ($past(rd_data, 2) & ~$past(m, 4)))
        else $error("clear write wrong");
    a_set_write: assert property (tk && instr[11:10] == 2'h1 |-> ##4 wr_en &&
        wr_addr == $past(instr[6:0], 4) && wr_data == ($past(rd_data, 2) | $past(m, 4)))
        else $error("set write wrong");
    a_skip_clear: assert property (tk && instr[11:10] == 2'h2 |-> ##4 !wr_en &&
        skip_next == !($past(rd_data, 2) & $past(m, 4))) else $error("skip wrong");
    a_flush_len: assert property (skip_next |=> nop_cycle [*4] ##1 !nop_cycle)
        else $error("flush length wrong");
    a_flush_quiet: assert property (nop_cycle |-> !wr_en && !skip_next)
        else $error("flushed word acted");
    a_other_quiet: assert property (phase == 2'h0 && instr_valid &&
        (instr[13:12] != 2'h1 || instr[11:10] == 2'h3) |-> ##4 !wr_en && !skip_next)
        else $error("foreign word acted");
    a_cycle_mark: assert property (phase == 2'h3 |=> cycle_end && phase == 2'h0)
        else $error("cycle end missing");
    a_mark_q1_only: assert property (cycle_end |-> phase == 2'h0)
        else $error("cycle end out of place");
    a_busy_span: assert property (phase == 2'h0 && (instr_valid || skip_next) |=>
        busy [*3] ##1 !busy) else $error("busy span wrong");
    a_busy_idle: assert property (phase == 2'h0 && !instr_valid && !skip_next |=> !busy)
        else $error("busy while idle");
    cover property (skip_next);
    cover property (wr_en ##4 wr_en);
    cover property (nop_cycle ##4 wr_en);
endmodule // boxu_exec_props
bind boxu_exec boxu_exec_props p (.clk_sys, .arst_n, .instr_valid, .wr_en, .skip_next,
    .nop_cycle, .instr, .rd_data, .wr_data, .wr_addr, .phase, .cycle_end, .busy);

/* boxu_file_model.sv */
`timescale 1ns/1ps
module boxu_file_model (
    input  wire logic       clk_sys,
    input  wire logic [6:0] rd_addr,
    input  wire logic       rd_en,
    output wire logic [7:0] rd_data,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en
);
    logic [7:0] mem [0:127];
    logic [7:0] junk_r = 8'h00;
    // churn when unselected so a late sample never sees real data
    assign rd_data = rd_en ? mem[rd_addr] : junk_r;
    always @(posedge clk_sys) begin
        junk_r <= junk_r + 8'h3B;
        if (wr_en) mem[wr_addr] <= wr_data;
    end
endmodule // boxu_file_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, skp = 1'b0;
    logic [13:0] instr = 14'h0000;
    wire  [6:0]  rd_addr, wr_addr;
    wire  [7:0]  rd_data, wr_data;
    wire  [1:0]  phase;
    wire         rd_en, wr_en, status_wr_en, skip_next, nop_cycle;
    logic [7:0]  sh [0:127];
    logic [15:0] q [$];
    int          n_fail = 0, checked = 0, i;
    always #2 clk_sys = ~clk_sys;
    boxu_exec uut (.clk_sys, .arst_n, .instr, .instr_valid, .rd_addr, .rd_en, .rd_data,
        .wr_addr, .wr_data, .wr_en, .status_wr_en, .skip_next, .nop_cycle, .phase,
        .cycle_end(), .busy());
    boxu_file_model fm (.clk_sys, .rd_addr, .rd_en, .rd_data, .wr_addr, .wr_data, .wr_en);
    task chk(input string nm, input [15:0] s, input [15:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    task conclude;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task iss(input [13:0] w);
        logic [7:0] v;
        v = sh[w[6:0]];
        do @(posedge clk_sys); while (phase !== 2'h3);
        instr <= w;
        instr_valid <= 1'b1;
        if (!skp && w[13:12] == 2'h1 && w[11:10] != 2'h3) begin
            if (w[11]) begin
                skp = !v[w[9:7]];
                if (skp) q.push_back(16'h8000);
            end else begin
                v[w[9:7]] = w[10];
                sh[w[6:0]] = v;
                q.push_back({1'b0, w[6:0], v});
            end
        end else skp = 1'b0;
    endtask
    always @(posedge clk_sys) if (wr_en === 1'b1 || skip_next === 1'b1) begin
        chk("write_or_skip", {skip_next, skip_next ? 15'h0000 : {wr_addr, wr_data}},
            q.size() > 0 ? q.pop_front() : 16'hFFFF);
        chk("status_wr_en", {15'h0000, status_wr_en}, 16'h0000);
    end
    initial begin
        void'($urandom(32'hB4D6));
        for (i = 0; i < 128; i++) begin
            sh[i] = 8'($urandom);
            fm.mem[i] = sh[i];
        end
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (i = 0; i < 16; i++) iss({2'h1, 1'b0, i[3], i[2:0], {7{i[3]}}});
        $display("bit boundaries done");
        for (i = 0; i < 300; i++) iss({($urandom % 4 != 0) ? 2'h1 : 2'($urandom), 12'($urandom)});
        // stop feeding, else the last word is run again every instruction cycle
        do @(posedge clk_sys); while (phase !== 2'h3);
        instr_valid <= 1'b0;
        $display("random stream done");
        repeat (12) @(posedge clk_sys);
        chk("queue_left", 16'(q.size()), 16'h0000);
        conclude;
    end
    initial begin
        #20000;
        n_fail++;
        conclude;
    end
endmodule // tb_top
